// File: logic/dpm_top.sv
// Purpose: maps the differentiated-services code of IP frames to a priority
// Assumes: frame and register strobes come from logic on the core clock
// Notes:   lookup and register read each answer two edges after request
`timescale 1ns/1ps
// Function
// - index is traffic byte bits 7 to 2
// - codes 0x00 to 0x33 decoded to own entry, codes above give zero
// - selected field becomes frame priority
// - byte 0x90 holds codes 0x00 to 0x03
// - byte 0x91 holds codes 0x04 to 0x07
// - next bytes ascend, 0x9C holds 0x30-0x33
// - fields read/write, reset to zero
// - IPv4 and IPv6 share one table
module dpm_top
	import dpm_pkg::*;
(
	// clock, reset, enable
	input  wire logic       CLK,
	input  wire logic       RESET,
	input  wire logic       CE,
	// register port
	input  wire logic       REG_WR,
	input  wire logic       REG_RD,
	input  wire logic [7:0] REG_ADDR,
	input  wire logic [7:0] REG_WDATA,
	output logic      [7:0] REG_RDATA,
	output logic            REG_RVALID,
	// frame classifier side
	input  wire logic       FRM_VALID,
	input  wire logic       FRM_IPV4,
	input  wire logic       FRM_IPV6,
	input  wire logic [7:0] FRM_TOS,
	// queue side
	output logic            PRI_VALID,
	output logic            PRI_HIT,
	output logic      [1:0] PRI_VALUE
);
	dpm_tbl_if tbl_if ();                  // path to the table storage

	logic                  map_hit;        // address inside the table
	logic [7:0]            addr_off;       // address less table base
	logic                  frm_ip;         // frame carries an IP header
	logic                  s1_valid_q;     // lookup stage valid
	logic                  s1_ip_q;        // lookup stage frame is IP
	logic [DPM_CODE_W-1:0] s1_code_q;      // lookup stage code
	logic                  s1_rd_q;        // read stage valid
	logic [7:0]            rdata_q;        // read data to software
	logic                  rvalid_q;       // read data marker
	logic                  pri_valid_q;    // priority marker
	logic                  pri_hit_q;      // priority came from table
	logic [1:0]            pri_value_q;    // priority to queues

	// one byte per four codes from the base upward
	assign addr_off = REG_ADDR - DSCP_MAP_CODES_00_03;
	assign map_hit  = REG_ADDR >= DSCP_MAP_CODES_00_03 && REG_ADDR <= DSCP_MAP_CODES_30_33;
	// either IP version takes the same path
	assign frm_ip   = FRM_IPV4 | FRM_IPV6;

	// writes outside the table are dropped silently
	assign tbl_if.wr_en   = REG_WR & map_hit;
	assign tbl_if.wr_idx  = addr_off[DPM_IDX_W-1:0];
	assign tbl_if.wr_data = REG_WDATA;
	// unmapped reads still answer, with zero
	assign tbl_if.rd_en   = REG_RD;
	assign tbl_if.rd_hit  = map_hit;
	assign tbl_if.rd_idx  = addr_off[DPM_IDX_W-1:0];
	// code is the upper six bits of the traffic byte
	assign tbl_if.lk_code = FRM_TOS[7:DPM_CODE_LSB];

	// table bytes kept in storage, cleared on reset
	dpm_store u_store (
		.clk (CLK),
		.rst (RESET),
		.ce  (CE),
		.tbl (tbl_if.store)
	);

	// pipeline timing, two enabled edges from request to answer:
	//   edge 1: storage registers the read byte and the lookup field,
	//           stage one registers the frame flags and the read strobe
	//   edge 2: output stage takes the registered storage values
	// both paths share the same depth, so a frame and a read issued
	// together answer together, which keeps the queue side simple.
	// a write lands at its own edge, so a lookup issued on the next
	// cycle already sees the new field; the cost is that a write and
	// a read of the same byte at one edge return the old byte.
	// CE low holds every stage, so answers slip by the frozen cycles
	// and nothing is lost or repeated.
	// the output stage is kept apart from storage so that every
	// top-level output leaves from a flop of this module.

	// first stage runs beside the storage read
	always_ff @(posedge CLK) begin
		if (RESET) begin
			s1_valid_q <= 1'b0;
			s1_ip_q    <= 1'b0;
			s1_code_q  <= '0;
			s1_rd_q    <= 1'b0;
		end else if (CE) begin
			s1_valid_q <= FRM_VALID;
			s1_ip_q    <= frm_ip;
			s1_code_q  <= tbl_if.lk_code;
			s1_rd_q    <= REG_RD;
		end
	end

	// output stage; all outputs leave from these flops
	always_ff @(posedge CLK) begin
		if (RESET) begin
			pri_valid_q <= 1'b0;
			pri_hit_q   <= 1'b0;
			pri_value_q <= DPM_PRI_LOWEST;
			rvalid_q    <= 1'b0;
			rdata_q     <= DPM_REG_RESET;
		end else if (CE) begin
			pri_valid_q <= s1_valid_q;
			// non-IP frames leave priority to others
			pri_hit_q   <= s1_valid_q & s1_ip_q;
			pri_value_q <= (s1_valid_q && s1_ip_q) ? tbl_if.lk_pri : DPM_PRI_LOWEST;
			rvalid_q    <= s1_rd_q;
			// held until the next read, so software may sample late
			if (s1_rd_q)
				rdata_q <= tbl_if.rd_data;
		end
	end

	assign PRI_VALID  = pri_valid_q;
	assign PRI_HIT    = pri_hit_q;
	assign PRI_VALUE  = pri_value_q;
	assign REG_RVALID = rvalid_q;
	assign REG_RDATA  = rdata_q;

	// checks on the map; a frozen enable inside a check's window voids that attempt rather than stalling it
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);
	// decode, frame flags and storage field are watched directly, so a
	// fault in either the decode or the pipe shows up here

	// code taken from bits 7 to 2
	code_take_a: assert property (
		(CE && FRM_VALID) |=> s1_code_q == $past(FRM_TOS[7:2]))
		else $error("lookup code not taken from traffic byte bits 7 to 2");
	// codes without a field give zero
	code_range_a: assert property (
		(CE && s1_valid_q && s1_code_q > DPM_LAST_CODE) |=> PRI_VALUE == 2'h0)
		else $error("code without stored field gave nonzero priority");
	pri_select_a: assert property (
		(CE && s1_valid_q && s1_ip_q) |=> PRI_VALUE == $past(tbl_if.lk_pri))
		else $error("priority differs from selected table field");
	// top pair of the first byte
	first_byte_a: assert property (
		(CE && REG_WR && REG_ADDR == 8'h90) ##1
		(CE && !REG_WR && FRM_VALID && FRM_IPV4 && FRM_TOS[7:2] == 6'h03) ##1 CE
		|=> PRI_VALUE == $past(REG_WDATA[7:6], 3))
		else $error("code 0x03 not mapped to bits 7:6 of first byte");
	// low pair of the second byte
	second_byte_a: assert property (
		(CE && REG_WR && REG_ADDR == 8'h91) ##1
		(CE && !REG_WR && FRM_VALID && FRM_IPV4 && FRM_TOS[7:2] == 6'h04) ##1 CE
		|=> PRI_VALUE == $past(REG_WDATA[1:0], 3))
		else $error("code 0x04 not mapped to bits 1:0 of second byte");
	// second pair of the last byte
	last_byte_a: assert property (
		(CE && REG_WR && REG_ADDR == 8'h9C) ##1
		(CE && !REG_WR && FRM_VALID && FRM_IPV6 && FRM_TOS[7:2] == 6'h31) ##1 CE
		|=> PRI_VALUE == $past(REG_WDATA[3:2], 3))
		else $error("code 0x31 not mapped to bits 3:2 of last byte");
	read_back_a: assert property (
		(CE && REG_WR && map_hit) ##1
		(CE && REG_RD && !REG_WR && REG_ADDR == $past(REG_ADDR)) ##1 CE
		|=> REG_RVALID && REG_RDATA == $past(REG_WDATA, 3))
		else $error("table byte did not read back as written");
	v6_lookup_a: assert property (
		(CE && FRM_VALID && FRM_IPV6 && !FRM_IPV4) ##1 CE |=> PRI_VALID && PRI_HIT)
		else $error("IPv6 frame did not use the table");
	// other frames get no table priority
	non_ip_a: assert property (
		(CE && FRM_VALID && !frm_ip) ##1 CE |=> PRI_VALID && !PRI_HIT && PRI_VALUE == 2'h0)
		else $error("non-IP frame was given a table priority");


	// stage one follows the frame strobe
	stage_valid_a: assert property (
		CE |=> s1_valid_q == $past(FRM_VALID))
		else $error("lookup stage lost or invented a frame");
	// IPv4 frames use the table too
	v4_lookup_a: assert property (
		(CE && FRM_VALID && FRM_IPV4) ##1 CE |=> PRI_VALID && PRI_HIT)
		else $error("IPv4 frame did not use the table");
	// reads outside the table answer zero
	unmapped_rd_a: assert property (
		(CE && REG_RD && !map_hit) ##1 CE |=> REG_RVALID && REG_RDATA == 8'h00)
		else $error("read outside the table did not answer zero");
	// read answer two enabled edges on
	rvalid_pulse_a: assert property (
		(CE && REG_RD) ##1 CE |=> REG_RVALID)
		else $error("read answer pulse missing");
	// no table priority without a hit
	pri_zero_a: assert property (
		(PRI_VALID && !PRI_HIT) |-> PRI_VALUE == 2'h0)
		else $error("priority given without a table hit");
	ce_freeze_a: assert property (
		!CE |=> $stable(PRI_VALUE) && $stable(REG_RDATA) &&
		$stable(PRI_VALID) && $stable(REG_RVALID))
		else $error("output moved while the enable was low");
	reset_out_a: assert property (
		@(posedge CLK) disable iff (1'b0)
		RESET |=> !PRI_VALID && !PRI_HIT && !REG_RVALID && PRI_VALUE == 2'h0 &&
		REG_RDATA == 8'h00)
		else $error("output not cleared by reset");

	cov_stall_c:  cover property (!CE && s1_rd_q);
	cov_write_c:  cover property (CE && REG_WR && map_hit);
	cov_ip_hit_c: cover property (PRI_VALID && PRI_HIT && PRI_VALUE == 2'h3);
	cov_non_ip_c: cover property (PRI_VALID && !PRI_HIT);
	cov_read_c:   cover property (REG_RVALID && REG_RDATA != 8'h00);
endmodule // dpm_top

// File: logic/dpm_pkg.sv
// Purpose: constants shared by the differentiated-services priority map
// Assumes: byte-wide register port, 100 MHz core clock
// Notes:   table bytes sit at consecutive byte addresses, four codes per byte
package dpm_pkg;
	// register byte addresses, one per group of four codes
	localparam logic [7:0] DSCP_MAP_CODES_00_03 = 8'h90;
	localparam logic [7:0] DSCP_MAP_CODES_04_07 = 8'h91;
	localparam logic [7:0] DSCP_MAP_CODES_08_0B = 8'h92;
	localparam logic [7:0] DSCP_MAP_CODES_0C_0F = 8'h93;
	localparam logic [7:0] DSCP_MAP_CODES_10_13 = 8'h94;
	localparam logic [7:0] DSCP_MAP_CODES_14_17 = 8'h95;
	localparam logic [7:0] DSCP_MAP_CODES_18_1B = 8'h96;
	localparam logic [7:0] DSCP_MAP_CODES_1C_1F = 8'h97;
	localparam logic [7:0] DSCP_MAP_CODES_20_23 = 8'h98;
	localparam logic [7:0] DSCP_MAP_CODES_24_27 = 8'h99;
	localparam logic [7:0] DSCP_MAP_CODES_28_2B = 8'h9A;
	localparam logic [7:0] DSCP_MAP_CODES_2C_2F = 8'h9B;
	localparam logic [7:0] DSCP_MAP_CODES_30_33 = 8'h9C;
	// table geometry
	localparam int         DPM_NUM_REGS    = 13;
	localparam int         DPM_IDX_W       = 4;
	localparam int         DPM_CODE_W      = 6;
	localparam int         DPM_PRI_W       = 2;
	localparam int         DPM_CODE_LSB    = 2;
	localparam logic [5:0] DPM_LAST_CODE   = 6'h33;
	// reset values
	localparam logic [7:0] DPM_REG_RESET   = 8'h00;
	localparam logic [1:0] DPM_PRI_LOWEST  = 2'h0;
endpackage

// File: logic/dpm_tbl_if.sv
// Purpose: carries table access between the map front end and its storage
// Assumes: single core clock, owner drives all strobes
// Notes:   lookup and register read share no port, so neither stalls
`timescale 1ns/1ps
interface dpm_tbl_if;
	import dpm_pkg::*;
	logic                  wr_en;    // write one table byte
	logic [DPM_IDX_W-1:0]  wr_idx;   // byte index of write
	logic [7:0]            wr_data;  // byte to store
	logic                  rd_en;    // read one table byte
	logic                  rd_hit;   // read address lies in the table
	logic [DPM_IDX_W-1:0]  rd_idx;   // byte index of read
	logic [7:0]            rd_data;  // registered read byte
	logic [DPM_CODE_W-1:0] lk_code;  // code of the frame under lookup
	logic [DPM_PRI_W-1:0]  lk_pri;   // registered priority field
	modport front (output wr_en, wr_idx, wr_data, rd_en, rd_hit, rd_idx, lk_code,
		input rd_data, lk_pri);
	modport store (input wr_en, wr_idx, wr_data, rd_en, rd_hit, rd_idx, lk_code,
		output rd_data, lk_pri);
endinterface

// File: logic/dpm_store.sv
// Purpose: byte storage of the priority table with two registered read ports
// Assumes: indices checked by the front end for reads, here for lookups
// Notes:   codes beyond the last stored byte return the lowest priority
`timescale 1ns/1ps
module dpm_store
	import dpm_pkg::*;
(
	// clock and control
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic ce,
	// table access
	dpm_tbl_if.store  tbl
);
	logic [7:0]           ent_q [DPM_NUM_REGS]; // one byte per four codes
	logic [7:0]           rd_q;                 // register read byte
	logic [DPM_PRI_W-1:0] pri_q;                // lookup result
	logic                 lk_in_tbl;            // code has a stored field
	logic [7:0]           lk_byte;              // byte owning the code
	logic [DPM_PRI_W-1:0] lk_field;             // selected bit pair

	// one write decoder per byte; every field clears to lowest priority
	genvar g;
	for (g = 0; g < DPM_NUM_REGS; g++) begin : g_ent
		always_ff @(posedge clk) begin
			if (rst)
				ent_q[g] <= DPM_REG_RESET;
			else if (ce && tbl.wr_en && tbl.wr_idx == DPM_IDX_W'(g))
				ent_q[g] <= tbl.wr_data;
		end
	end

	// each code up to 0x33 owns its own bit pair
	assign lk_in_tbl = tbl.lk_code <= DPM_LAST_CODE;
	assign lk_byte   = lk_in_tbl ? ent_q[tbl.lk_code[5:2]] : DPM_REG_RESET;
	// lowest code of a byte in bits 1:0
	assign lk_field  = lk_byte[{tbl.lk_code[1:0], 1'b0} +: DPM_PRI_W];

	// both read ports registered so output timing is fixed
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_q  <= DPM_REG_RESET;
			pri_q <= DPM_PRI_LOWEST;
		end else if (ce) begin
			if (tbl.rd_en)
				rd_q <= tbl.rd_hit ? ent_q[tbl.rd_idx] : DPM_REG_RESET;
			pri_q <= lk_field;
		end
	end

	assign tbl.rd_data = rd_q;
	assign tbl.lk_pri  = pri_q;
endmodule // dpm_store

// File: verif/tb_dpm_top.sv
// Purpose: self-checking bench for the priority map top
// Assumes: CE mostly high, inputs driven on the falling clock edge
// Notes:   expected table bytes kept locally, never read back from the design
`timescale 1ns/1ps
module tb_dpm_top;
	import dpm_pkg::*;
	// clock, reset, enable
	logic       clk;
	logic       rst;
	logic       ce;
	// register port
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic       reg_rvalid;
	// frame and queue side
	logic       frm_valid;
	logic       frm_ipv4;
	logic       frm_ipv6;
	logic [7:0] frm_tos;
	logic       pri_valid;
	logic       pri_hit;
	logic [1:0] pri_value;
	// bench state
	logic [7:0] exp_tbl [DPM_NUM_REGS];
	int         err_count;
	int         cmp_count;

	dpm_top u_dpm_top (.CLK(clk), .RESET(rst), .CE(ce), .REG_WR(reg_wr), .REG_RD(reg_rd),
		.REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
		.REG_RVALID(reg_rvalid), .FRM_VALID(frm_valid), .FRM_IPV4(frm_ipv4),
		.FRM_IPV6(frm_ipv6), .FRM_TOS(frm_tos), .PRI_VALID(pri_valid), .PRI_HIT(pri_hit),
		.PRI_VALUE(pri_value));

	// free-running 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// counts and verdict, the only exit
	task automatic end_of_test();
		$display("errors %0d compares %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// one comparison, x never matches
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	// bounded wait for a one-cycle answer pulse
	task automatic wait_pulse(ref logic flag);
		int n;
		n = 0;
		while (flag !== 1'b1 && n < 4) begin
			@(negedge clk);
			n++;
		end
		if (flag !== 1'b1) begin
			err_count++;
			$display("mismatch at %0t: answer pulse never came", $time);
			end_of_test();
		end
	endtask

	task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
		@(negedge clk);
		reg_wr = 1'b1; reg_addr = addr; reg_wdata = data;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask

	task automatic reg_read_chk(input logic [7:0] addr, input logic [7:0] exp);
		@(negedge clk);
		reg_rd = 1'b1; reg_addr = addr;
		@(negedge clk);
		reg_rd = 1'b0;
		wait_pulse(reg_rvalid);
		check(reg_rdata, exp, "register read");
	endtask

	task automatic lookup_chk(input logic v4, input logic v6, input logic [7:0] tos,
		input logic hit, input logic [1:0] val);
		@(negedge clk);
		frm_valid = 1'b1; frm_ipv4 = v4; frm_ipv6 = v6; frm_tos = tos;
		@(negedge clk);
		frm_valid = 1'b0;
		wait_pulse(pri_valid);
		check({7'h00, pri_hit}, {7'h00, hit}, "lookup hit");
		check({6'h00, pri_value}, {6'h00, val}, "lookup priority");
	endtask

	// expected field of one code from the local table
	function automatic logic [1:0] field_of(input logic [5:0] c);
		logic [7:0] b;
		if (c > DPM_LAST_CODE) return DPM_PRI_LOWEST;
		b = exp_tbl[c[5:2]];
		return b[2*c[1:0] +: 2];
	endfunction

	// every byte reads zero after reset, lookups give lowest priority
	task automatic t_reset_values();
		for (int i = 0; i < DPM_NUM_REGS; i++) begin
			exp_tbl[i] = DPM_REG_RESET;
			reg_read_chk(DSCP_MAP_CODES_00_03 + 8'(i), DPM_REG_RESET);
		end
		lookup_chk(1'b1, 1'b0, 8'h14, 1'b1, DPM_PRI_LOWEST);
	endtask

	// distinct bytes per address, unmapped places stay silent
	task automatic t_write_read();
		for (int i = 0; i < DPM_NUM_REGS; i++) begin
			exp_tbl[i] = 8'h1B + 8'(i) * 8'h25;
			reg_write(DSCP_MAP_CODES_00_03 + 8'(i), exp_tbl[i]);
		end
		reg_write(8'h9D, 8'hFF);
		reg_write(8'h8F, 8'hFF);
		for (int i = 0; i < DPM_NUM_REGS; i++)
			reg_read_chk(DSCP_MAP_CODES_00_03 + 8'(i), exp_tbl[i]);
		reg_read_chk(8'h9D, 8'h00);
		reg_read_chk(8'h8F, 8'h00);
	endtask

	// all 64 codes, low byte bits scrambled, v4 and v6 alternating
	task automatic t_lookup_all();
		logic [5:0] c;
		for (int i = 0; i < 64; i++) begin
			c = 6'(i);
			lookup_chk(c[0], ~c[0], {c, ~c[1:0]}, 1'b1, field_of(c));
		end
	endtask

	// non-IP frames bypass the table, both flags count as IP
	task automatic t_non_ip();
		lookup_chk(1'b0, 1'b0, 8'hCC, 1'b0, DPM_PRI_LOWEST);
		lookup_chk(1'b1, 1'b1, 8'hCC, 1'b1, field_of(6'h33));
	endtask

	// write, then next cycle read the same byte and look up one of its codes
	task automatic t_back_to_back(input logic [7:0] addr, input logic [7:0] data,
		input logic v6, input logic [7:0] tos);
		@(negedge clk);
		reg_wr = 1'b1; reg_addr = addr; reg_wdata = data;
		exp_tbl[addr - DSCP_MAP_CODES_00_03] = data;
		@(negedge clk);
		reg_wr = 1'b0; reg_rd = 1'b1;
		frm_valid = 1'b1; frm_ipv4 = ~v6; frm_ipv6 = v6; frm_tos = tos;
		@(negedge clk);
		reg_rd = 1'b0; frm_valid = 1'b0;
		wait_pulse(pri_valid);
		check({7'h00, reg_rvalid}, 8'h01, "read answer with frame");
		check(reg_rdata, data, "read after write");
		check({7'h00, pri_hit}, 8'h01, "back to back hit");
		check({6'h00, pri_value}, {6'h00, field_of(tos[7:2])}, "fresh field");
	endtask

	// enable low for two cycles delays the read answer by two
	task automatic t_ce_stall();
		@(negedge clk);
		reg_rd = 1'b1; reg_addr = DSCP_MAP_CODES_04_07;
		@(negedge clk);
		reg_rd = 1'b0; ce = 1'b0;
		@(negedge clk);
		check({7'h00, reg_rvalid}, 8'h00, "answer while frozen");
		@(negedge clk);
		check({7'h00, reg_rvalid}, 8'h00, "answer while frozen");
		ce = 1'b1;
		wait_pulse(reg_rvalid);
		check(reg_rdata, exp_tbl[1], "stalled read");
	endtask

	// reset in mid-run clears read data, priority and the table bytes at 0x91 and 0x9C
	task automatic t_mid_reset();
		@(negedge clk);
		rst = 1'b1;
		repeat (2) @(negedge clk);
		check(reg_rdata, 8'h00, "read data in reset");
		check({6'h00, pri_value}, 8'h00, "priority in reset");
		rst = 1'b0;
		for (int i = 0; i < DPM_NUM_REGS; i++)
			exp_tbl[i] = DPM_REG_RESET;
		reg_read_chk(DSCP_MAP_CODES_04_07, DPM_REG_RESET);
		lookup_chk(1'b1, 1'b0, 8'hC4, 1'b1, DPM_PRI_LOWEST);
	endtask

	// write at the edge before a frame is seen by that frame
	task automatic t_write_then_lookup();
		@(negedge clk);
		reg_wr = 1'b1; reg_addr = DSCP_MAP_CODES_00_03; reg_wdata = 8'h80;
		exp_tbl[0] = 8'h80;
		@(negedge clk);
		reg_wr = 1'b0;
		frm_valid = 1'b1; frm_ipv4 = 1'b1; frm_ipv6 = 1'b0; frm_tos = 8'h0C;
		@(negedge clk);
		frm_valid = 1'b0;
		wait_pulse(pri_valid);
		check({6'h00, pri_value}, {6'h00, field_of(6'h03)}, "fresh write lookup");
	endtask

	// main sequence
	initial begin
		err_count = 0; cmp_count = 0;
		rst = 1'b1; ce = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00;
		reg_wdata = 8'h00; frm_valid = 1'b0; frm_ipv4 = 1'b0; frm_ipv6 = 1'b0; frm_tos = 8'h00;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		t_reset_values();
		t_write_read();
		t_lookup_all();
		t_non_ip();
		t_write_then_lookup();
		t_back_to_back(DSCP_MAP_CODES_04_07, 8'hA7, 1'b0, 8'h10);
		t_back_to_back(DSCP_MAP_CODES_30_33, 8'h5C, 1'b1, 8'hC4);
		t_ce_stall();
		t_mid_reset();
		end_of_test();
	end
endmodule // tb_dpm_top
